// ==== sfdp_pkg.sv ====
/*
 * Package for the flash parameter block: fixed parameter words, status
 * layout, instruction codes, register map, timing and carrier types.
 * Assumes a single 40 MHz clock and an APB register port.
 */
package sfdp_pkg;

   // ==========================================================
   // Clock and power-down exit timing
   // ==========================================================
   localparam int CLK_MHZ          = 40;
   localparam logic [1:0] EXIT_UNIT_CODE = 2'h1;
   localparam int EXIT_UNIT_NS     = 1000;
   localparam logic [4:0] EXIT_COUNT_CODE = 5'h1d;
   localparam int EXIT_DELAY_NS    = (int'(EXIT_COUNT_CODE) + 1)
                                     * EXIT_UNIT_NS;
   localparam int EXIT_CYCLES      = (EXIT_DELAY_NS * CLK_MHZ + 999) / 1000;
   localparam int TMR_W            = 11;

   // ==========================================================
   // Parameter doublewords and field positions
   // ==========================================================
   localparam logic [31:0] DW14_VALUE = 32'h5cd5bdf7;
   localparam logic [31:0] DW15_VALUE = 32'hff5df68c;
   localparam int UNIT_LSB   = 13;
   localparam int COUNT_LSB  = 8;
   localparam int POLL_LSB   = 2;
   localparam logic [1:0] POLL_LEGACY = 2'h1;
   localparam int HOLD_DIS_BIT = 23;
   localparam int QUAD_REQ_LSB = 20;
   localparam logic [2:0] QUAD_REQ_STATUS2_BIT1 = 3'h5;

   // ==========================================================
   // Status bytes
   // ==========================================================
   localparam int WRITE_IN_PROGRESS_BIT = 0;
   localparam int QUAD_IO_ENABLE_BIT    = 1;
   localparam logic [7:0] SR1_RESET = 8'h00;
   localparam logic [7:0] SR2_RESET = 8'h00;

   // ==========================================================
   // Instructions
   // ==========================================================
   localparam logic [7:0] INS_WRITE_SR  = 8'h01;
   localparam logic [7:0] INS_READ_SR1  = 8'h05;
   localparam logic [7:0] INS_READ_SR2  = 8'h35;
   localparam logic [7:0] INS_ENTER_DPD = 8'hb9;
   localparam logic [7:0] INS_EXIT_DPD  = 8'hab;

   // ==========================================================
   // Register map (byte addresses)
   // ==========================================================
   localparam logic [7:0] ADDR_DW14   = 8'h00;
   localparam logic [7:0] ADDR_DW15   = 8'h04;
   localparam logic [7:0] ADDR_CMD    = 8'h08;
   localparam logic [7:0] ADDR_RESP   = 8'h0c;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam int CMD_D1_LSB = 8;
   localparam int CMD_D2_LSB = 16;

   // ==========================================================
   // Types
   // ==========================================================
   typedef enum logic [2:0] {
      PWR_ACTIVE = 3'b001,
      PWR_DOWN   = 3'b010,
      PWR_WAKING = 3'b100
   } pwr_state_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic [7:0] ins;
      logic [7:0] dataOne;
      logic [7:0] dataTwo;
   } flash_cmd_t;

endpackage

// ==== sfdp_powerdown_polling_params.sv ====
/*
 * Flash parameter and status block: read-only parameter doublewords,
 * two status bytes with busy and quad-enable bits, and the deep
 * power-down exit delay, driven by instructions written over APB.
 * Assumes one clock, a synchronous active-high reset and a compliant
 * APB master.
 */
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps

//Contract
// - Delay unit field reads 01b, one microsecond
// - Delay count reads 11101b, thirty microseconds total
// - Busy polled by 05h, flag in bit 0
// - Busy flag one while busy, zero ready
// - Doubleword 14 reads 5C D5 BD F7
// - Doubleword 15 top byte reads all ones
// - Hold and protect disable reported as zero
// - Quad-enable requirement field reads 101b
// - Write status 01h, second byte bit1 sets
// - 35h returns status two, 05h status one
module sfdp_powerdown_polling_params
   import sfdp_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // Device state
   input  wire logic        opBusy,
   output logic             quadIoEnable,
   output logic             deepPowerDown
);

   // ==========================================================
   // APB slave
   // ==========================================================
   apb_req_t    req;
   flash_cmd_t  cmd;
   logic        accessDone;
   logic        cmdExec;
   logic        knownAddr;
   logic        pready_reg, pready_next;
   logic        pslverr_reg, pslverr_next;
   logic [31:0] prdata_reg, prdata_next;
   logic [31:0] readMux;

   pwr_state_t       pwr_reg, pwr_next;
   logic [TMR_W-1:0] tmr_reg, tmr_next;
   logic [7:0]       sr1_reg, sr1_next;
   logic [7:0]       sr2_reg, sr2_next;
   logic [7:0]       resp_reg, resp_next;
   logic             writeInProgressFlag;

   assign req = '{psel: psel, penable: penable, pwrite: pwrite,
                  paddr: paddr, pwdata: pwdata};
   assign accessDone = req.psel && req.penable && pready_reg;
   assign cmd = '{ins: req.pwdata[7:0],
                  dataOne: req.pwdata[CMD_D1_LSB +: 8],
                  dataTwo: req.pwdata[CMD_D2_LSB +: 8]};
   assign cmdExec = accessDone && req.pwrite && req.paddr == ADDR_CMD;

   // Busy while an internal operation runs or the exit delay counts
   assign writeInProgressFlag = opBusy || pwr_reg == PWR_WAKING;

   always_comb begin
      knownAddr = 1'b1;
      case (req.paddr)
         ADDR_DW14:   readMux = DW14_VALUE;
         ADDR_DW15:   readMux = DW15_VALUE;
         ADDR_CMD:    readMux = 32'h0000_0000;
         ADDR_RESP:   readMux = {24'h00_0000, resp_reg};
         ADDR_STATUS: readMux = {13'h0000, pwr_reg, sr2_reg,
                                 sr1_reg[7:1], writeInProgressFlag};
         default: begin
            readMux   = 32'h0000_0000;
            knownAddr = 1'b0;
         end
      endcase
   end

   // One wait state: pready rises in the second access cycle
   always_comb begin
      pready_next  = 1'b0;
      pslverr_next = 1'b0;
      prdata_next  = prdata_reg;
      if (req.psel && req.penable && !pready_reg) begin
         pready_next  = 1'b1;
         pslverr_next = !knownAddr ||
                        (req.pwrite && req.paddr != ADDR_CMD);
         prdata_next  = req.pwrite ? 32'h0000_0000 : readMux;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
      end else begin
         pready_reg  <= pready_next;
         pslverr_reg <= pslverr_next;
         prdata_reg  <= prdata_next;
      end
   end

   // ==========================================================
   // Instruction execution and power state
   // ==========================================================
   always_comb begin
      pwr_next  = pwr_reg;
      tmr_next  = tmr_reg;
      sr1_next  = sr1_reg;
      sr2_next  = sr2_reg;
      resp_next = resp_reg;
      case (pwr_reg)
         PWR_ACTIVE: begin
            if (cmdExec) begin
               case (cmd.ins)
                  INS_READ_SR1:
                     resp_next = {sr1_reg[7:1], writeInProgressFlag};
                  INS_READ_SR2:
                     resp_next = sr2_reg;
                  INS_WRITE_SR: begin
                     if (!writeInProgressFlag) begin
                        sr1_next = {cmd.dataOne[7:1], 1'b0};
                        sr2_next = cmd.dataTwo;
                     end
                  end
                  INS_ENTER_DPD: begin
                     if (!writeInProgressFlag) begin
                        pwr_next = PWR_DOWN;
                     end
                  end
                  default: resp_next = resp_reg;
               endcase
            end
         end
         PWR_DOWN: begin
            if (cmdExec && cmd.ins == INS_EXIT_DPD) begin
               pwr_next = PWR_WAKING;
               tmr_next = TMR_W'(EXIT_CYCLES - 1);
            end
         end
         PWR_WAKING: begin
            // Status polling still answers during the exit delay
            if (cmdExec && cmd.ins == INS_READ_SR1) begin
               resp_next = {sr1_reg[7:1], writeInProgressFlag};
            end else if (cmdExec && cmd.ins == INS_READ_SR2) begin
               resp_next = sr2_reg;
            end
            if (tmr_reg == '0) begin
               pwr_next = PWR_ACTIVE;
            end else begin
               tmr_next = tmr_reg - TMR_W'(1);
            end
         end
         default: pwr_next = PWR_ACTIVE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pwr_reg      <= PWR_ACTIVE;
         tmr_reg      <= '0;
         sr1_reg      <= SR1_RESET;
         sr2_reg      <= SR2_RESET;
         resp_reg     <= 8'h00;
         quadIoEnable <= 1'b0;
         deepPowerDown <= 1'b0;
      end else begin
         pwr_reg      <= pwr_next;
         tmr_reg      <= tmr_next;
         sr1_reg      <= sr1_next;
         sr2_reg      <= sr2_next;
         resp_reg     <= resp_next;
         quadIoEnable <= sr2_next[QUAD_IO_ENABLE_BIT];
         deepPowerDown <= pwr_next != PWR_ACTIVE;
      end
   end

   assign pready  = pready_reg;
   assign prdata  = prdata_reg;
   assign pslverr = pslverr_reg;

   // ==========================================================
   // Assertions
   // ==========================================================
   // Elaboration check: the exit delay must fit the down-counter
   if (EXIT_CYCLES >= (1 << TMR_W) || EXIT_CYCLES < 1) begin : g_tmr_chk
      $error("Exit delay counter too narrow");
   end

   sequence s_read_done(logic [7:0] a);
      pready && !pwrite && paddr == a && psel && penable;
   endsequence

   property p_unit_field;
      @(posedge ref_clk) disable iff (rst)
      s_read_done(ADDR_DW14) |-> prdata[UNIT_LSB +: 2] == 2'h1;
   endproperty
   a_unit_field: assert property (p_unit_field)
      else $error("Exit delay unit field wrong");

   property p_count_field;
      @(posedge ref_clk) disable iff (rst)
      s_read_done(ADDR_DW14) |-> prdata[COUNT_LSB +: 5] == 5'h1d;
   endproperty
   a_count_field: assert property (p_count_field)
      else $error("Exit delay count field wrong");

   property p_dw14;
      @(posedge ref_clk) disable iff (rst)
      s_read_done(ADDR_DW14) |-> prdata == 32'h5cd5bdf7
                                 && prdata[POLL_LSB +: 2] == 2'h1;
   endproperty
   a_dw14: assert property (p_dw14)
      else $error("Doubleword 14 wrong");

   property p_dw15;
      @(posedge ref_clk) disable iff (rst)
      s_read_done(ADDR_DW15) |-> prdata[31:24] == 8'hff;
   endproperty
   a_dw15: assert property (p_dw15)
      else $error("Doubleword 15 top byte wrong");

   property p_hold_dis;
      @(posedge ref_clk) disable iff (rst)
      s_read_done(ADDR_DW15) |-> !prdata[HOLD_DIS_BIT];
   endproperty
   a_hold_dis: assert property (p_hold_dis)
      else $error("Hold disable bit set");

   property p_quad_req;
      @(posedge ref_clk) disable iff (rst)
      s_read_done(ADDR_DW15) |-> prdata[QUAD_REQ_LSB +: 3] == 3'h5;
   endproperty
   a_quad_req: assert property (p_quad_req)
      else $error("Quad-enable requirement wrong");

   // Waking cycles are counted here so the exit delay length is
   // checked without unrolling a long delay range
   logic [TMR_W-1:0] wakeCnt_reg, wakeCnt_next;

   always_comb begin
      wakeCnt_next = '0;
      if (pwr_reg == PWR_WAKING) begin
         wakeCnt_next = wakeCnt_reg + TMR_W'(1);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wakeCnt_reg <= '0;
      end else begin
         wakeCnt_reg <= wakeCnt_next;
      end
   end

   sequence s_exit_cmd;
      cmdExec && cmd.ins == INS_EXIT_DPD && pwr_reg == PWR_DOWN;
   endsequence

   property p_wake_busy;
      @(posedge ref_clk) disable iff (rst)
      s_exit_cmd |=> writeInProgressFlag [*8] ##1 deepPowerDown;
   endproperty
   a_wake_busy: assert property (p_wake_busy)
      else $error("Exit delay busy window wrong");

   property p_wake_len;
      @(posedge ref_clk) disable iff (rst)
      $fell(pwr_reg == PWR_WAKING) |->
         wakeCnt_reg == TMR_W'(EXIT_CYCLES) && !deepPowerDown;
   endproperty
   a_wake_len: assert property (p_wake_len)
      else $error("Exit delay length wrong");

   property p_busy_idle;
      @(posedge ref_clk) disable iff (rst)
      (cmdExec && cmd.ins == INS_READ_SR1 && !opBusy
       && pwr_reg == PWR_ACTIVE) |=> !resp_reg[WRITE_IN_PROGRESS_BIT];
   endproperty
   a_busy_idle: assert property (p_busy_idle)
      else $error("Busy flag set while ready");

   property p_poll_sr1;
      @(posedge ref_clk) disable iff (rst)
      (cmdExec && cmd.ins == INS_READ_SR1 && pwr_reg != PWR_DOWN)
      |=> resp_reg[WRITE_IN_PROGRESS_BIT] == $past(writeInProgressFlag);
   endproperty
   a_poll_sr1: assert property (p_poll_sr1)
      else $error("Status poll lost busy flag");

   property p_quad_write;
      @(posedge ref_clk) disable iff (rst)
      (cmdExec && cmd.ins == INS_WRITE_SR && pwr_reg == PWR_ACTIVE
       && !writeInProgressFlag)
      |=> quadIoEnable == $past(pwdata[CMD_D2_LSB + QUAD_IO_ENABLE_BIT]);
   endproperty
   a_quad_write: assert property (p_quad_write)
      else $error("Quad-enable not written");

   property p_sr2_read;
      @(posedge ref_clk) disable iff (rst)
      (cmdExec && cmd.ins == INS_READ_SR2 && pwr_reg != PWR_DOWN)
      |=> resp_reg[QUAD_IO_ENABLE_BIT] == quadIoEnable;
   endproperty
   a_sr2_read: assert property (p_sr2_read)
      else $error("Status two read wrong");

endmodule

// ==== apb_host_model.sv ====
/*
 * Behavioural APB host standing for the controller that reads the
 * flash parameters and polls the status bytes.
 * Assumes the slave answers with pready sampled on a rising edge.
 */
`timescale 1ns/1ps

module apb_host_model
   import sfdp_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // APB master side
   output apb_req_t         req,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr
);
   // ==========================================================
   // Transfers
   // ==========================================================
   initial req = '0;

   // Idle address and data lines show the inverse of the last value; pwrite keeps its last value
   task automatic xfer(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] rdata,
         output logic e);
      @(posedge ref_clk);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge ref_clk);
      req.penable <= 1'b1;
      // Only the bench watchdog ends a wait that never completes
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rdata = prdata;
      e = pslverr;
      req <= '{1'b0, 1'b0, w, ~a, ~d};
   endtask
endmodule

// ==== tb_sfdp_powerdown_polling_params.sv ====
/*
 * Self-checking bench for the flash parameter block: parameter
 * words, status polling, status writes and power-down exit delay.
 * Assumes the APB host model and the design package.
 */
`timescale 1ns/1ps

module tb_sfdp_powerdown_polling_params
   import sfdp_pkg::*;
;
   // ==========================================================
   // Signals
   // ==========================================================
   logic        ref_clk = 1'b0;
   logic        rst     = 1'b1;
   logic        opBusy  = 1'b0;
   apb_req_t    req;
   logic        pready, pslverr, quadIoEnable, deepPowerDown;
   logic [31:0] prdata;
   logic [31:0] seed = 32'h88ad;
   int          err_total = 0;
   int          tests_run = 0;

   always #12.5 ref_clk = ~ref_clk;

   sfdp_powerdown_polling_params u_dut (
      .ref_clk(ref_clk), .rst(rst), .psel(req.psel),
      .penable(req.penable), .pwrite(req.pwrite), .paddr(req.paddr),
      .pwdata(req.pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .opBusy(opBusy),
      .quadIoEnable(quadIoEnable), .deepPowerDown(deepPowerDown));

   apb_host_model u_host (
      .ref_clk(ref_clk), .rst(rst), .req(req), .pready(pready),
      .prdata(prdata), .pslverr(pslverr));

   // ==========================================================
   // Helpers
   // ==========================================================
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [7:0] expSr1(logic [7:0] sr, logic b);
      return {sr[7:1], b};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] want,
         input string what);
      tests_run++;
      if (got !== want) begin
         err_total++;
         $display("MISMATCH at %0t: %s got %h want %h", $time, what,
                  got, want);
      end
   endtask

   task automatic done(input string n);
      $display("test %s finished", n);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
         output logic e);
      u_host.xfer(1'b0, a, 32'h0, d, e);
   endtask

   task automatic cmd(input logic [7:0] ins, d1, d2, output logic e);
      logic [31:0] x;
      u_host.xfer(1'b1, ADDR_CMD, {8'h00, d2, d1, ins}, x, e);
   endtask

   task automatic stat(input logic [7:0] ins, output logic [7:0] s);
      logic        e;
      logic [31:0] d;
      cmd(ins, 8'h00, 8'h00, e);
      rd(ADDR_RESP, d, e);
      s = d[7:0];
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      #(25 * 10000);
      err_total++;
      end_sim();
   end

   // ==========================================================
   // Tests
   // ==========================================================
   initial begin
      logic [31:0] d;
      logic        e;
      logic [7:0]  s, sr1, sr2;
      longint      t0;
      int          i;
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      chk(32'({pready, quadIoEnable, deepPowerDown}), 32'h0, "reset");
      rd(ADDR_DW14, d, e);
      chk(d, 32'h5cd5bdf7, "word 14");
      chk(32'(d[14:13]), 32'h1, "delay unit");
      chk(32'(d[12:8]), 32'h1d, "delay count");
      chk(32'(d[3:2]), 32'h1, "poll method");
      chk(32'({d[7:4], d[1:0]}), 32'h3f, "reserved bits");
      rd(ADDR_DW15, d, e);
      chk(32'(d[31:24]), 32'hff, "word 15 top");
      chk(32'(d[23]), 32'h0, "hold disable");
      chk(32'(d[22:20]), 32'h5, "quad requirement");
      u_host.xfer(1'b1, ADDR_DW14, rnd(), d, e);
      chk(32'(e), 32'h1, "read-only write");
      rd(ADDR_DW14, d, e);
      chk(d, 32'h5cd5bdf7, "word 14 kept");
      rd(8'h40, d, e);
      chk({d[30:0], e}, 32'h1, "unmapped");
      done("params");
      sr1 = 8'h00;
      sr2 = 8'h00;
      for (i = 0; i < 12; i++) begin
         d = rnd();
         if (i < 2)
            d = (i == 0) ? 32'h0002a500 : 32'h00005a00;
         opBusy <= d[0];
         cmd(INS_WRITE_SR, d[15:8], d[23:16], e);
         chk(32'(e), 32'h0, "command accepted");
         if (!d[0]) begin
            sr1 = {d[15:9], 1'b0};
            sr2 = d[23:16];
         end
         stat(INS_READ_SR1, s);
         chk(32'(s), 32'(expSr1(sr1, d[0])), "status one");
         stat(INS_READ_SR2, s);
         chk(32'(s), 32'(sr2), "status two");
         chk(32'(quadIoEnable), 32'(sr2[1]), "quad pin");
      end
      done("status");
      opBusy <= 1'b1;
      cmd(INS_ENTER_DPD, 8'h00, 8'h00, e);
      @(posedge ref_clk);
      chk(32'(deepPowerDown), 32'h0, "entry refused while busy");
      opBusy <= 1'b0;
      cmd(INS_ENTER_DPD, 8'h00, 8'h00, e);
      rd(ADDR_STATUS, d, e);
      chk(32'({d[18:8], d[0]}), 32'({PWR_DOWN, sr2, 1'b0}),
          "status while down");
      cmd(INS_WRITE_SR, 8'h00, ~sr2, e);
      cmd(INS_EXIT_DPD, 8'h00, 8'h00, e);
      t0 = $time;
      chk(32'(deepPowerDown), 32'h1, "power-down pin");
      s = 8'h01;
      i = 0;
      while (s[0] === 1'b1 && i < 400) begin
         stat(INS_READ_SR1, s);
         i++;
      end
      i = int'(($time - t0) / 25);
      chk(32'(i >= 1200 && i < 1230), 32'h1, "exit delay");
      repeat (2) @(posedge ref_clk);
      chk(32'(deepPowerDown), 32'h0, "awake pin");
      rd(ADDR_STATUS, d, e);
      chk(32'({d[18:16], d[0]}), 32'({PWR_ACTIVE, 1'b0}),
          "status awake");
      stat(INS_READ_SR2, s);
      chk(32'(s), 32'(sr2), "write ignored while down");
      done("power-down");
      end_sim();
   end
endmodule
